// ### core/eeprom_access_arbiter_ctrl.sv
// Contract
// - two write policies, fcfs and rf-priority, picked by a config byte field
// - fcfs with no write running accepts a write from either side
// - fcfs rf write during host write gets a nak and is not done
// - fcfs host write during rf write raises the access conflict event
// - rf-priority: field appearing aborts the host write and raises conflict event
// - rf-priority: rf read or write aborts host write, serves rf, raises conflict
// - harvesting output only in power modes 0 and 1
// - resistance code 00 off and tristate, 01 100, 10 50, 11 25 ohm
// - voltage code 0 is 1.9 V, +0.1 V per code to 4.5 V, above 1.8 V
// - power mode 3 keeps device powered while external power is present
// - silent mode with low host supply disables rf and ignores rf commands
// - 32-bit password guards user memory for reads, writes or both
// - rf write to password block authenticates; seven failures lock
// - after authentication the rf user may write a new password
// - password checks only on rf accesses, host accesses bypass them
// - wake-up event to host on selectable events
// - link-disable byte kills tunneling and extended modes or all rf
// - link-disable byte writable only from the host side
// - power mode 1 without tunneling or extended forces resistance to zero
`timescale 1ns/100ps
`default_nettype none

module eeprom_access_arbiter_ctrl
	import arb_pkg::*;
#(
	parameter logic [7:0]  PWD_BLOCK_ADDR = 8'h2b,
	parameter logic [31:0] PWD_INIT       = PWD_RST
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// configuration
	input  wire logic [7:0]  arbitration_silent_config_byte,
	input  wire logic [7:0]  regulator_config_byte,
	input  wire logic [1:0]  power_mode,
	input  wire logic        tunnel_mode_en,
	input  wire logic        ext_mode_en,
	input  wire logic [7:0]  auth_limit_addr,
	input  wire logic        prot_read_en,
	input  wire logic        prot_write_en,
	input  wire logic [3:0]  wake_select,
	// pins
	input  wire logic        field_power_on_detect,
	input  wire logic        host_supply_pin,
	// rf side requests
	input  wire logic        rf_wr_req,
	input  wire logic        rf_rd_req,
	input  wire logic [7:0]  rf_addr,
	input  wire logic [31:0] rf_wdata,
	// host side requests
	input  wire logic        host_wr_req,
	input  wire logic        host_kill_wr,
	input  wire logic [1:0]  host_kill_data,
	input  wire logic        host_auth_clr,
	// eeprom engine
	input  wire logic        ee_done,
	output logic             ee_wr_start,
	output logic             ee_wr_from_rf,
	output logic             ee_abort,
	// rf answers
	output logic             rf_ack,
	output logic             rf_nak,
	output logic             rf_rd_grant,
	// host answers
	output logic             host_wr_done,
	output logic             host_wr_refused,
	output logic             host_wr_aborted,
	output logic             acc_conflict,
	// status
	output logic             rf_enabled,
	output logic             tunnel_allowed,
	output logic             authenticated,
	output logic             auth_locked,
	output logic [1:0]       kill_state,
	output logic             keep_powered,
	// rf tag events and wake-up
	input  wire logic        ev_selected,
	input  wire logic        ev_sleep_req,
	input  wire logic        ev_mem_update,
	output logic             wake_irq,
	// harvesting
	output logic             harvest_output_pin_oe,
	output logic [1:0]       harvest_res_sel,
	output logic [12:0]      harvest_mv
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] field_sync_reg;
	logic [1:0] supply_sync_reg;
	logic       field_prev_reg;
	// two stages each; logic reads only the second stage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			field_sync_reg  <= 2'b00;
			supply_sync_reg <= 2'b11;
			field_prev_reg  <= 1'b0;
		end else if (clk_en) begin
			field_sync_reg  <= {field_sync_reg[0], field_power_on_detect};
			supply_sync_reg <= {supply_sync_reg[0], host_supply_pin};
			field_prev_reg  <= field_sync_reg[1];
		end
	end

	logic field_on, field_rise, supply_low;
	assign field_on   = field_sync_reg[1];
	assign field_rise = field_sync_reg[1] && !field_prev_reg;
	assign supply_low = !supply_sync_reg[1];   // comparator output, low means below threshold

	// ----------------------------------------
	// link-disable and rf gating
	// ----------------------------------------
	logic [1:0] kill_reg;

	// only the host port reaches this byte; rf has no path to it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			kill_reg <= KILL_RST;
		end else if (clk_en && host_kill_wr) begin
			kill_reg <= host_kill_data;
		end
	end

	logic arb_mode;
	assign arb_mode   = arbitration_silent_config_byte[CFG0_ARB_BIT];
	assign rf_enabled = !(arbitration_silent_config_byte[CFG0_SILENT_BIT] && supply_low)
		&& !kill_reg[KILL_RF_BIT];
	assign tunnel_allowed = (tunnel_mode_en || ext_mode_en) && !kill_reg[KILL_TUNNEL_BIT];
	assign kill_state     = kill_reg;
	assign keep_powered   = (power_mode == PM_EXT_SUPPLY);

	// ----------------------------------------
	// password protection
	// ----------------------------------------
	logic [31:0] pwd_reg;
	logic        auth_reg;
	logic        rf_wr_v, rf_rd_v, pwd_hit, prot_area, auth_fail, auth_ok;
	logic        pwd_change, rf_wr_denied, rf_rd_denied;

	// rf requests vanish while the rf part is off
	assign rf_wr_v    = rf_wr_req && rf_enabled;
	assign rf_rd_v    = rf_rd_req && rf_enabled;
	assign pwd_hit    = (rf_addr == PWD_BLOCK_ADDR);
	assign prot_area  = (rf_addr >= auth_limit_addr);
	assign auth_ok    = rf_wr_v && pwd_hit && !auth_reg && !auth_locked && rf_wdata == pwd_reg;
	assign auth_fail  = rf_wr_v && pwd_hit && !auth_reg && !auth_locked && rf_wdata != pwd_reg;
	assign pwd_change = rf_wr_v && pwd_hit && auth_reg;
	// host requests never pass through these checks
	assign rf_wr_denied = rf_wr_v && !pwd_hit && prot_area && prot_write_en && !auth_reg;
	assign rf_rd_denied = rf_rd_v && prot_area && prot_read_en && !auth_reg;

	fail_counter #(
		.LIMIT (AUTH_FAIL_MAX)
	) u_fail (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.inc     (auth_fail),
		.clr     (host_auth_clr),
		.locked  (auth_locked)
	);

	// authentication lasts until the field drops or the host clears the counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			auth_reg <= 1'b0;
			pwd_reg  <= PWD_INIT;
		end else if (clk_en) begin
			if (auth_ok) begin
				auth_reg <= 1'b1;
			end else if (!field_on || host_auth_clr) begin
				auth_reg <= 1'b0;
			end
			if (pwd_change) begin
				pwd_reg <= rf_wdata;
			end
		end
	end

	assign authenticated = auth_reg;

	// ----------------------------------------
	// write arbitration
	// ----------------------------------------
	arb_state_e state_reg;
	arb_state_e state_next;
	logic       rf_wr_plain, rf_preempt, field_preempt;

	// password-block writes and denied writes never reach the eeprom engine
	assign rf_wr_plain   = rf_wr_v && !pwd_hit && !rf_wr_denied;
	assign rf_preempt    = arb_mode == ARB_RF_PRIO && field_on && (rf_wr_plain || rf_rd_v);
	assign field_preempt = arb_mode == ARB_RF_PRIO && field_rise;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (rf_wr_plain) begin
					state_next = ST_RF_WR;
				end else if (host_wr_req) begin
					state_next = ST_HOST_WR;
				end
			end
			ST_HOST_WR: begin
				if (rf_preempt && rf_wr_plain) begin
					state_next = ST_RF_WR;
				end else if (ee_done || rf_preempt || field_preempt) begin
					state_next = ST_IDLE;
				end
			end
			ST_RF_WR: begin
				if (ee_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// answers registered one edge after their cause; all one-cycle pulses except ee_wr_from_rf, which holds the owner
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ee_wr_start     <= 1'b0;
			ee_wr_from_rf   <= 1'b0;
			ee_abort        <= 1'b0;
			rf_ack          <= 1'b0;
			rf_nak          <= 1'b0;
			rf_rd_grant     <= 1'b0;
			host_wr_done    <= 1'b0;
			host_wr_refused <= 1'b0;
			host_wr_aborted <= 1'b0;
			acc_conflict    <= 1'b0;
		end else if (clk_en) begin
			ee_wr_start     <= state_next != state_reg && state_next != ST_IDLE;
			if (state_next == ST_RF_WR) begin
				ee_wr_from_rf <= 1'b1;
			end else if (state_next == ST_HOST_WR) begin
				ee_wr_from_rf <= 1'b0;
			end
			ee_abort        <= state_reg == ST_HOST_WR && !ee_done && (rf_preempt || field_preempt);
			// rf write done, or password accepted or changed
			rf_ack          <= (state_reg == ST_RF_WR && ee_done) || auth_ok || pwd_change;
			rf_nak          <= auth_fail || rf_wr_denied || rf_rd_denied
				|| (rf_wr_v && pwd_hit && auth_locked)
				|| (rf_wr_plain && state_reg == ST_RF_WR)
				|| (rf_wr_plain && state_reg == ST_HOST_WR && !rf_preempt);
			rf_rd_grant     <= rf_rd_v && !rf_rd_denied
				&& (state_reg != ST_HOST_WR || arb_mode == ARB_RF_PRIO);
			host_wr_done    <= state_reg == ST_HOST_WR && ee_done;
			host_wr_refused <= host_wr_req && (state_reg != ST_IDLE || rf_wr_plain);
			host_wr_aborted <= state_reg == ST_HOST_WR && !ee_done && (rf_preempt || field_preempt);
			acc_conflict    <= (host_wr_req && state_reg == ST_RF_WR)
				|| (state_reg == ST_HOST_WR && !ee_done && (rf_preempt || field_preempt));
		end
	end

	// ----------------------------------------
	// wake-up events
	// ----------------------------------------
	logic pup_reg;

	// power-up event fires once on the first enabled edge after reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pup_reg  <= 1'b1;
			wake_irq <= 1'b0;
		end else if (clk_en) begin
			pup_reg  <= 1'b0;
			wake_irq <= (pup_reg && wake_select[WK_POWER_UP])
				|| (ev_selected && wake_select[WK_SELECTED])
				|| (ev_sleep_req && wake_select[WK_SLEEP])
				|| (ev_mem_update && wake_select[WK_MEM_UPD]);
		end
	end

	// ----------------------------------------
	// energy harvesting settings
	// ----------------------------------------
	logic [1:0] rreg_eff;
	logic [4:0] vreg;
	logic       pm_harvest;

	assign pm_harvest = (power_mode == PM_DEFAULT) || (power_mode == PM_RF_ONLY);
	assign vreg       = regulator_config_byte[CFG1_VREG_LSB +: 5];

	// battery-less mode without a host link has no use for the output
	always_comb begin
		rreg_eff = regulator_config_byte[CFG1_RREG_LSB +: 2];
		if (!pm_harvest || (power_mode == PM_RF_ONLY && !tunnel_mode_en && !ext_mode_en)) begin
			rreg_eff = RREG_OFF;
		end
	end

	// registered so the analog trim never sees decode glitches
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			harvest_res_sel       <= RREG_OFF;
			harvest_output_pin_oe <= 1'b0;
			harvest_mv            <= VREG_SPARE_MV;
		end else if (clk_en) begin
			harvest_res_sel       <= rreg_eff;
			harvest_output_pin_oe <= rreg_eff != RREG_OFF;
			if (vreg <= VREG_TOP) begin
				harvest_mv <= VREG_BASE_MV + VREG_STEP_MV * {8'h00, vreg};
			end else begin
				harvest_mv <= VREG_SPARE_MV;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	fcfs_rf_nak_a: assert property (clk_en && arb_mode == ARB_FCFS && state_reg == ST_HOST_WR
		&& rf_wr_plain ##1 clk_en |-> rf_nak && !ee_wr_from_rf)
		else $error("rf write during host write not refused");
	fcfs_host_conflict_a: assert property (clk_en && host_wr_req && state_reg == ST_RF_WR
		|=> acc_conflict && host_wr_refused)
		else $error("host write during rf write raised no conflict");
	field_abort_a: assert property (clk_en && arb_mode == ARB_RF_PRIO && state_reg == ST_HOST_WR
		&& field_rise && !ee_done |=> ee_abort && acc_conflict && host_wr_aborted)
		else $error("field rise did not abort host write");
	rf_preempt_a: assert property (clk_en && state_reg == ST_HOST_WR && rf_preempt && rf_wr_plain
		&& !ee_done |=> state_reg == ST_RF_WR && ee_wr_start && ee_wr_from_rf)
		else $error("rf write did not take over");
	abort_not_done_a: assert property (host_wr_aborted |-> !host_wr_done ##1 !host_wr_done)
		else $error("aborted write reported done");
	harvest_mode_a: assert property (clk_en && !pm_harvest |=> !harvest_output_pin_oe)
		else $error("harvest on outside modes 0 and 1");
	pm1_force_off_a: assert property (clk_en && power_mode == PM_RF_ONLY && !tunnel_mode_en
		&& !ext_mode_en |=> harvest_res_sel == RREG_OFF)
		else $error("resistance not forced off");
	vreg_top_a: assert property (clk_en && vreg == VREG_TOP |=> harvest_mv == 13'd4500)
		else $error("top voltage code wrong");
	silent_ignore_a: assert property (!rf_enabled && !$past(rf_enabled) && clk_en
		&& state_reg == ST_IDLE |=> !rf_ack && !rf_nak && !rf_rd_grant)
		else $error("rf answered while disabled");
	lock_stops_auth_a: assert property (clk_en && auth_locked && !auth_reg |=> !auth_reg)
		else $error("locked device authenticated");
	kill_host_only_a: assert property (clk_en && !host_kill_wr |=> $stable(kill_reg))
		else $error("link-disable byte changed without host");

	cv_preempt_c: cover property (ee_abort ##1 state_reg == ST_RF_WR);
	cv_lock_c: cover property (auth_fail ##[1:40] auth_locked);
	cv_fcfs_nak_c: cover property (rf_nak && arb_mode == ARB_FCFS);

endmodule

`default_nettype wire

// ### core/fail_counter.sv
`timescale 1ns/100ps
`default_nettype none

module fail_counter
	import arb_pkg::*;
#(
	parameter logic [2:0] LIMIT = AUTH_FAIL_MAX
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// count control
	input  wire logic inc,
	input  wire logic clr,
	// state
	output logic      locked
);

	logic [2:0] cnt_reg;

	// saturating failure count; a failure in the cycle of a host clear still counts
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= 3'h0;
		end else if (clk_en) begin
			if (clr) begin
				cnt_reg <= {2'b00, inc};
			end else if (inc && cnt_reg != LIMIT) begin
				cnt_reg <= cnt_reg + 3'h1;
			end
		end
	end

	assign locked = (cnt_reg == LIMIT);

endmodule

`default_nettype wire

// ### inc/arb_pkg.sv
package arb_pkg;

	// ----------------------------------------
	// configuration byte fields
	// ----------------------------------------
	localparam int CFG0_ARB_BIT    = 0;   // arbitration policy select
	localparam int CFG0_SILENT_BIT = 1;   // silent mode enable
	localparam int CFG1_RREG_LSB   = 0;   // output resistance selector
	localparam int CFG1_VREG_LSB   = 2;   // output voltage selector
	localparam int KILL_TUNNEL_BIT = 0;   // tunneling / extended disabled
	localparam int KILL_RF_BIT     = 1;   // rf communication disabled

	// ----------------------------------------
	// codes and reset values
	// ----------------------------------------
	localparam logic       ARB_FCFS     = 1'b0;
	localparam logic       ARB_RF_PRIO  = 1'b1;
	localparam logic [1:0] PM_DEFAULT   = 2'h0;
	localparam logic [1:0] PM_RF_ONLY   = 2'h1;
	localparam logic [1:0] PM_EXT_SUPPLY = 2'h3;
	localparam logic [1:0] RREG_OFF     = 2'h0;
	localparam logic [4:0] VREG_TOP     = 5'h1a;       // last code of the linear range
	localparam logic [12:0] VREG_BASE_MV  = 13'd1900;
	localparam logic [12:0] VREG_STEP_MV  = 13'd100;
	localparam logic [12:0] VREG_SPARE_MV = 13'd1800;
	localparam logic [1:0] KILL_RST     = 2'h0;
	localparam logic [2:0] AUTH_FAIL_MAX = 3'h7;
	localparam logic [31:0] PWD_RST     = 32'h0000_0000;

	// ----------------------------------------
	// wake-up event select bits
	// ----------------------------------------
	localparam int WK_POWER_UP = 0;
	localparam int WK_SELECTED = 1;
	localparam int WK_SLEEP    = 2;
	localparam int WK_MEM_UPD  = 3;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_HOST_WR = 2'b01,
		ST_RF_WR  = 2'b10
	} arb_state_e;

endpackage

// ### verif/ee_engine_model.sv
`timescale 1ns/100ps
`default_nettype none

module ee_engine_model #(
	parameter int WR_CYCLES = 6
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// write engine handshake
	input  wire logic ee_wr_start,
	input  wire logic ee_abort,
	output logic      ee_done
);

	// ----------------------------------------
	// write timer
	// ----------------------------------------
	// cycles left on the write in progress, zero when idle
	int remain;

	// a start beats an abort in the same cycle, so a preempting write restarts the timer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			remain  <= 0;
			ee_done <= 1'b0;
		end else begin
			ee_done <= (remain == 1);
			if (ee_wr_start)
				remain <= WR_CYCLES;
			else if (ee_abort)
				remain <= 0;   // an aborted write reports done only if the abort lands in its last cycle
			else if (remain > 0)
				remain <= remain - 1;
		end
	end

endmodule
`default_nettype wire

// ### verif/eeprom_access_arbiter_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_access_arbiter_ctrl_tb;
	import arb_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        clk = 1'b0, sys_rst = 1'b1;
	logic [7:0]  cfg0 = 8'h00, cfg1 = 8'h00, lim = 8'hf0, addr = 8'h10;
	logic [1:0]  pmode = 2'h0, kill_d = 2'h0;
	logic        tun_en = 1'b0, ext_en = 1'b0, prd = 1'b0, pwr = 1'b0;
	logic [3:0]  wsel = 4'h1;
	logic        field = 1'b0, supply = 1'b1, rf_wr = 1'b0, rf_rd = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        h_wr = 1'b0, kill_wr = 1'b0, aclr = 1'b0;
	logic [2:0]  ev = 3'h0;
	logic        ee_done, ee_wr_start, ee_wr_from_rf, ee_abort, rf_ack, rf_nak, rf_rd_grant;
	logic        h_done, h_ref, h_abt, acc_conflict, rf_enabled, tunnel_allowed;
	logic        authenticated, auth_locked, keep_powered, wake_irq, oe;
	logic [1:0]  kill_state, res_sel;
	logic [12:0] mv;
	int          num_errors = 0;
	int          samples_checked = 0;

	always #5 clk = ~clk;

	eeprom_access_arbiter_ctrl uut (
		.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.arbitration_silent_config_byte(cfg0), .regulator_config_byte(cfg1),
		.power_mode(pmode), .tunnel_mode_en(tun_en), .ext_mode_en(ext_en),
		.auth_limit_addr(lim), .prot_read_en(prd), .prot_write_en(pwr), .wake_select(wsel),
		.field_power_on_detect(field), .host_supply_pin(supply),
		.rf_wr_req(rf_wr), .rf_rd_req(rf_rd), .rf_addr(addr), .rf_wdata(wdata),
		.host_wr_req(h_wr), .host_kill_wr(kill_wr), .host_kill_data(kill_d),
		.host_auth_clr(aclr), .ee_done(ee_done), .ee_wr_start(ee_wr_start),
		.ee_wr_from_rf(ee_wr_from_rf), .ee_abort(ee_abort), .rf_ack(rf_ack),
		.rf_nak(rf_nak), .rf_rd_grant(rf_rd_grant), .host_wr_done(h_done),
		.host_wr_refused(h_ref), .host_wr_aborted(h_abt), .acc_conflict(acc_conflict),
		.rf_enabled(rf_enabled), .tunnel_allowed(tunnel_allowed),
		.authenticated(authenticated), .auth_locked(auth_locked), .kill_state(kill_state),
		.keep_powered(keep_powered), .ev_selected(ev[0]), .ev_sleep_req(ev[1]),
		.ev_mem_update(ev[2]), .wake_irq(wake_irq), .harvest_output_pin_oe(oe),
		.harvest_res_sel(res_sel), .harvest_mv(mv)
	);

	// the eeprom engine answers a few cycles after each start
	ee_engine_model eng (
		.clk(clk), .sys_rst(sys_rst), .ee_wr_start(ee_wr_start), .ee_abort(ee_abort),
		.ee_done(ee_done)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chkv(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one-cycle request; returns at the falling edge where the answer stands
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	// bounded wait for a one-cycle answer; running out ends the run
	task automatic wait_hi(input string what, ref logic sig);
		for (int i = 0; i < 40 && sig !== 1'b1; i++)
			@(negedge clk);
		chk1(what, 1'b1, sig);
		if (sig !== 1'b1)
			results();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic host_write();
		pulse(h_wr);
		chk1("host start", 1'b1, ee_wr_start);
		chk1("owner host", 1'b0, ee_wr_from_rf);
		wait_hi("host done", h_done);
		cyc(1);
	endtask

	// fcfs: each side is turned away while the other writes
	task automatic fcfs_conflicts();
		pulse(h_wr);
		pulse(rf_wr);
		chk1("rf nak", 1'b1, rf_nak);
		chk1("no rf start", 1'b0, ee_wr_start);
		wait_hi("host done", h_done);
		cyc(1);
		pulse(rf_wr);
		chk1("rf owner", 1'b1, ee_wr_from_rf);
		pulse(h_wr);
		chk1("host refused", 1'b1, h_ref);
		chk1("conflict", 1'b1, acc_conflict);
		wait_hi("rf ack", rf_ack);
		cyc(1);
	endtask

	// rf priority: field rise and rf commands both abort the host write
	task automatic prio_aborts();
		cfg0 = 8'h01;
		field = 1'b0;
		cyc(3);
		pulse(h_wr);
		field = 1'b1;
		wait_hi("abort on field", ee_abort);
		chk1("conflict", 1'b1, acc_conflict);
		chk1("host aborted", 1'b1, h_abt);
		cyc(3);
		host_write();
		pulse(h_wr);
		pulse(rf_rd);
		chk1("abort on read", 1'b1, ee_abort);
		chk1("read grant", 1'b1, rf_rd_grant);
		chk1("conflict", 1'b1, acc_conflict);
		cyc(1);
		pulse(h_wr);
		pulse(rf_wr);
		chk1("abort on write", 1'b1, ee_abort);
		chk1("rf start", 1'b1, ee_wr_start);
		chk1("rf owner", 1'b1, ee_wr_from_rf);
		wait_hi("rf ack", rf_ack);
		cfg0 = 8'h00;
		cyc(1);
	endtask

	// one rf write to the password block, answer checked
	task automatic pwd_try(input logic [31:0] val, input logic ack);
		addr = 8'h2b;
		wdata = val;
		pulse(rf_wr);
		chk1("pwd ack", ack, rf_ack);
		chk1("pwd nak", !ack, rf_nak);
		cyc(1);
	endtask

	task automatic password();
		repeat (7) pwd_try(32'h1, 1'b0);
		chk1("locked", 1'b1, auth_locked);
		pwd_try(32'h0, 1'b0);
		pulse(aclr);
		cyc(1);
		pwd_try(32'h0, 1'b1);
		chk1("authed", 1'b1, authenticated);
		pwd_try(32'h5, 1'b1);
		pulse(aclr);
		cyc(1);
		pwd_try(32'h0, 1'b0);
		pwd_try(32'h5, 1'b1);
		pulse(aclr);
		lim = 8'h20;
		pwr = 1'b1;
		prd = 1'b1;
		addr = 8'h30;
		pulse(rf_wr);
		chk1("prot write nak", 1'b1, rf_nak);
		cyc(1);
		pulse(rf_rd);
		chk1("prot read nak", 1'b1, rf_nak);
		addr = 8'h10;
		cyc(1);
		pulse(rf_rd);
		chk1("public read", 1'b1, rf_rd_grant);
		host_write();
		{prd, pwr} = 2'b00;
	endtask

	// harvesting output decode by code and power mode
	task automatic harvest();
		for (int i = 0; i < 4; i++) begin
			cfg1 = 8'(i);
			cyc(2);
			chkv("res sel", 32'(i), 32'(res_sel));
			chk1("oe", i != 0, oe);
		end
		pmode = 2'h2;
		cyc(2);
		chk1("oe mode2", 1'b0, oe);
		pmode = 2'h1;
		cyc(2);
		chkv("res forced", 32'h0, 32'(res_sel));
		tun_en = 1'b1;
		cyc(2);
		chkv("res mode1", 32'h3, 32'(res_sel));
		chk1("oe mode1", 1'b1, oe);
		pmode = 2'h3;
		cyc(2);
		chk1("oe mode3", 1'b0, oe);
		chk1("kept powered", 1'b1, keep_powered);
		{pmode, tun_en} = 3'h0;
		for (int i = 0; i < 32; i++) begin
			cfg1 = {1'b0, 5'(i), 2'h1};
			cyc(2);
			chkv("mv", (i <= 26) ? 1900 + 100 * i : 1800, 32'(mv));
		end
	endtask

	// silent mode and chip kill both silence the rf side
	task automatic rf_gating();
		cfg0 = 8'h02;
		supply = 1'b0;
		cyc(3);
		chk1("silent off", 1'b0, rf_enabled);
		pulse(rf_wr);
		chk1("silent start", 1'b0, ee_wr_start);
		chk1("silent nak", 1'b0, rf_nak);
		supply = 1'b1;
		cyc(3);
		chk1("silent on", 1'b1, rf_enabled);
		tun_en = 1'b1;
		kill_d = 2'h1;
		pulse(kill_wr);
		cyc(1);
		chk1("tunnel killed", 1'b0, tunnel_allowed);
		chk1("rf alive", 1'b1, rf_enabled);
		kill_d = 2'h3;
		pulse(kill_wr);
		cyc(1);
		chk1("rf killed", 1'b0, rf_enabled);
		pulse(rf_wr);
		chk1("killed start", 1'b0, ee_wr_start);
		cyc(1);
		chkv("kill kept", 32'h3, 32'(kill_state));
	endtask

	// each rf event wake source fires only while selected
	task automatic wake();
		for (int i = 0; i < 3; i++) begin
			wsel = 4'h2 << i;
			ev = 3'h1 << i;
			cyc(1);
			ev = 3'h0;
			chk1("wake sel", 1'b1, wake_irq);
			cyc(1);
			wsel = 4'h0;
			ev = 3'h1 << i;
			cyc(1);
			ev = 3'h0;
			chk1("wake off", 1'b0, wake_irq);
			cyc(1);
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(6);
		sys_rst = 1'b0;
		cyc(1);
		chk1("power-up wake", 1'b1, wake_irq);
		field = 1'b1;
		cyc(3);
		host_write();
		fcfs_conflicts();
		prio_aborts();
		password();
		harvest();
		wake();
		rf_gating();
		results();
	end

endmodule
`default_nettype wire
